// File: rtl/lc_level_compressor.sv
// Level compressor configuration registers behind an AXI4-Lite slave
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module lc_level_compressor
  import lc_pkg::*;
(
  // Clock and reset
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  // Write address channel
  input  wire logic [lc_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  // Write data channel
  input  wire logic [lc_pkg::DATA_W-1:0]  s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  // Write response channel
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  // Read address channel
  input  wire logic [lc_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  // Read data channel
  output logic [lc_pkg::DATA_W-1:0]       s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  // Settings to the audio processor
  output var lc_pkg::lc_timing_t          compressor_timing_gain_limits_q,
  output var lc_pkg::lc_slopes_t          compressor_slopes_q,
  output var lc_pkg::lc_knee_t            compressor_knee_point_q
);
  import lc_pkg::*;

  // ----------------------------------------------------------------
  // Write path
  // ----------------------------------------------------------------
  logic                awready_q, wready_q, bvalid_q;
  logic [1:0]          bresp_q;
  logic                aw_full_q, w_full_q;
  logic [ADDR_W-1:0]   aw_addr_q;
  logic [DATA_W-1:0]   w_data_q;
  logic [3:0]          w_strb_q;
  wire                 aw_fire = s_axi_awvalid & awready_q;
  wire                 w_fire  = s_axi_wvalid & wready_q;
  // Both halves held and no response pending
  wire                 wr_go   = aw_full_q & w_full_q & ~bvalid_q;
  wire                 aw_full_d = (aw_full_q | aw_fire) & ~wr_go;
  wire                 w_full_d  = (w_full_q | w_fire) & ~wr_go;
  wire                 bvalid_d  = wr_go | (bvalid_q & ~s_axi_bready);
  wire [5:0]           wr_idx  = aw_addr_q[7:2];
  wire                 wr_tim  = wr_go & (wr_idx == IDX_TIMING);
  wire                 wr_slo  = wr_go & (wr_idx == IDX_SLOPES);
  wire                 wr_kne  = wr_go & (wr_idx == IDX_KNEE);
  wire                 wr_hit  = wr_tim | wr_slo | wr_kne;
  wire [REG_W-1:0]     wmask   = {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  wire [REG_W-1:0]     wnew    = w_data_q[REG_W-1:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      aw_addr_q <= '0;
      w_data_q  <= '0;
      w_strb_q  <= '0;
    end else begin
      awready_q <= ~aw_full_d & ~bvalid_d;
      wready_q  <= ~w_full_d & ~bvalid_d;
      aw_full_q <= aw_full_d;
      w_full_q  <= w_full_d;
      bvalid_q  <= bvalid_d;
      if (aw_fire) aw_addr_q <= s_axi_awaddr;
      if (w_fire) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_go) bresp_q <= wr_hit ? RESP_OKAY : RESP_SLV;
    end
  end

  // ----------------------------------------------------------------
  // Field merge with reserved-code filtering
  // ----------------------------------------------------------------
  lc_timing_t tim_m, tim_d;
  lc_slopes_t slo_m, slo_d;
  lc_knee_t   kne_m, kne_d;
  assign tim_m = (compressor_timing_gain_limits_q & ~wmask) | (wnew & wmask);
  assign slo_m = (compressor_slopes_q & ~wmask) | (wnew & wmask);
  assign kne_m = (compressor_knee_point_q & ~wmask) | (wnew & wmask);

  // Reserved codes are dropped per field so the processor never sees them
  always_comb begin
    tim_d = compressor_timing_gain_limits_q;
    slo_d = compressor_slopes_q;
    kne_d = compressor_knee_point_q;
    if (tim_m.gain_attack_rate >= ATK_MIN && tim_m.gain_attack_rate <= ATK_MAX)
      tim_d.gain_attack_rate = tim_m.gain_attack_rate;
    if (tim_m.gain_decay_rate <= DCY_MAX)
      tim_d.gain_decay_rate = tim_m.gain_decay_rate;
    tim_d.fast_release_crest_threshold = tim_m.fast_release_crest_threshold;
    if (tim_m.fast_release_decay_rate != QDCY_RSV)
      tim_d.fast_release_decay_rate = tim_m.fast_release_decay_rate;
    tim_d.gain_floor   = tim_m.gain_floor;
    tim_d.gain_ceiling = tim_m.gain_ceiling;
    if (slo_m.upper_slope <= UP_MAX) slo_d.upper_slope = slo_m.upper_slope;
    if (slo_m.lower_slope <= LO_MAX) slo_d.lower_slope = slo_m.lower_slope;
    if (kne_m.knee_input_level <= KIN_MAX)
      kne_d.knee_input_level = kne_m.knee_input_level;
    if (kne_m.knee_output_level <= KOUT_MAX)
      kne_d.knee_output_level = kne_m.knee_output_level;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      compressor_timing_gain_limits_q <= RST_TIMING;
      compressor_slopes_q             <= RST_SLOPES;
      compressor_knee_point_q         <= RST_KNEE;
    end else begin
      if (wr_tim) compressor_timing_gain_limits_q <= tim_d;
      if (wr_slo) compressor_slopes_q <= slo_d;
      if (wr_kne) compressor_knee_point_q <= kne_d;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic                arready_q, rvalid_q;
  logic [1:0]          rresp_q;
  logic [DATA_W-1:0]   rdata_q;
  wire                 ar_fire  = s_axi_arvalid & arready_q;
  wire                 rvalid_d = ar_fire | (rvalid_q & ~s_axi_rready);
  wire [5:0]           rd_idx   = s_axi_araddr[7:2];
  wire                 rd_tim   = rd_idx == IDX_TIMING;
  wire                 rd_slo   = rd_idx == IDX_SLOPES;
  wire                 rd_kne   = rd_idx == IDX_KNEE;
  wire [REG_W-1:0]     rd_val   = rd_tim ? compressor_timing_gain_limits_q :
                                  rd_slo ? compressor_slopes_q :
                                  rd_kne ? compressor_knee_point_q : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rresp_q   <= RESP_OKAY;
      rdata_q   <= '0;
    end else begin
      arready_q <= ~rvalid_d;
      rvalid_q  <= rvalid_d;
      if (ar_fire) begin
        // Upper half always zero; unmapped reads zero with error
        rdata_q <= {{(DATA_W-REG_W){1'b0}}, rd_val};
        rresp_q <= (rd_tim | rd_slo | rd_kne) ? RESP_OKAY : RESP_SLV;
      end
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  wire        full_wr = wr_tim & (w_strb_q[1:0] == 2'h3);
  lc_timing_t tim_w;
  lc_slopes_t slo_w;
  lc_knee_t   kne_w;
  assign tim_w = wnew;
  assign slo_w = wnew;
  assign kne_w = wnew;

  attack_legal_a: assert property (
    compressor_timing_gain_limits_q.gain_attack_rate inside {[ATK_MIN:ATK_MAX]})
    else $error("attack rate holds reserved code");
  decay_follow_a: assert property (
    full_wr && tim_w.gain_decay_rate <= DCY_MAX |=>
    compressor_timing_gain_limits_q.gain_decay_rate == $past(tim_w.gain_decay_rate))
    else $error("decay rate not taken from write");
  thr_follow_a: assert property (
    full_wr |=> compressor_timing_gain_limits_q.fast_release_crest_threshold
                == $past(tim_w.fast_release_crest_threshold))
    else $error("crest threshold not taken from write");
  qdcy_legal_a: assert property (
    compressor_timing_gain_limits_q.fast_release_decay_rate != QDCY_RSV)
    else $error("fast release decay holds reserved code");
  floor_follow_a: assert property (
    full_wr |=> compressor_timing_gain_limits_q.gain_floor == $past(tim_w.gain_floor))
    else $error("gain floor not taken from write");
  ceil_follow_a: assert property (
    full_wr |=> compressor_timing_gain_limits_q.gain_ceiling == $past(tim_w.gain_ceiling))
    else $error("gain ceiling not taken from write");
  upper_slope_a: assert property (
    wr_slo && w_strb_q[0] && slo_w.upper_slope <= UP_MAX |=>
    compressor_slopes_q.upper_slope == $past(slo_w.upper_slope))
    else $error("upper slope not taken from write");
  lower_slope_a: assert property (
    compressor_slopes_q.lower_slope <= LO_MAX)
    else $error("lower slope holds reserved code");
  knee_in_a: assert property (
    compressor_knee_point_q.knee_input_level <= KIN_MAX)
    else $error("knee input holds reserved code");
  knee_out_a: assert property (
    compressor_knee_point_q.knee_output_level <= KOUT_MAX)
    else $error("knee output holds reserved code");
  reset_value_a: assert property (
    $rose(aresetn) |-> compressor_timing_gain_limits_q == RST_TIMING &&
    compressor_slopes_q == RST_SLOPES && compressor_knee_point_q == RST_KNEE)
    else $error("register reset value wrong");
  rsv_keep_a: assert property (
    full_wr && !(tim_w.gain_attack_rate inside {[ATK_MIN:ATK_MAX]}) |=>
    $stable(compressor_timing_gain_limits_q.gain_attack_rate))
    else $error("reserved attack code changed setting");
  // Decode is gone one cycle after the write, so look back at it
  resp_timing_a: assert property (
    wr_go |=> s_axi_bvalid && s_axi_bresp == ($past(wr_hit) ? RESP_OKAY : RESP_SLV))
    else $error("write response missing or wrong");

  // ----------------------------------------------------------------
  // Bus handshake, read-back, spare-bit and unmapped-write checks
  // ----------------------------------------------------------------
  bvalid_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
  rvalid_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data changed before rready");
  wr_stall_a: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  rd_stall_a: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  rdata_upper_a: assert property (
    s_axi_rdata[DATA_W-1:REG_W] == '0)
    else $error("read data upper half not zero");
  tim_read_a: assert property (
    ar_fire && rd_tim |=>
    s_axi_rdata[REG_W-1:0] == $past(compressor_timing_gain_limits_q))
    else $error("timing read-back differs from register");
  slo_read_a: assert property (
    ar_fire && rd_slo |=> s_axi_rdata[REG_W-1:0] == $past(compressor_slopes_q))
    else $error("slopes read-back differs from register");
  kne_read_a: assert property (
    ar_fire && rd_kne |=> s_axi_rdata[REG_W-1:0] == $past(compressor_knee_point_q))
    else $error("knee read-back differs from register");
  slope_pad_a: assert property (
    compressor_slopes_q.unused == '0)
    else $error("slopes register spare bits set");
  knee_pad_a: assert property (
    compressor_knee_point_q.unused == '0)
    else $error("knee register spare bits set");
  miss_keep_a: assert property (
    wr_go && !wr_hit |=> $stable(compressor_timing_gain_limits_q) &&
    $stable(compressor_slopes_q) && $stable(compressor_knee_point_q))
    else $error("unmapped write changed a setting");

  tim_write_c:  cover property (wr_tim ##1 s_axi_bvalid && s_axi_bready);
  rsv_write_c:  cover property (full_wr && tim_w.gain_attack_rate == 4'h0);
  slo_read_c:   cover property (ar_fire && rd_slo ##1 s_axi_rvalid);
  bad_write_c:  cover property (wr_go && !wr_hit);
  bad_read_c:   cover property (ar_fire && !(rd_tim || rd_slo || rd_kne));

endmodule // lc_level_compressor

`default_nettype wire

// File: rtl/lc_pkg.sv
// Package for the level compressor configuration registers
package lc_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int          ADDR_W    = 8;
  localparam int          DATA_W    = 32;
  localparam int          REG_W     = 16;
  localparam logic [1:0]  RESP_OKAY = 2'h0;
  localparam logic [1:0]  RESP_SLV  = 2'h2;

  // ----------------------------------------------------------------
  // Register indices; byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_TIMING = 6'h29;
  localparam logic [5:0] IDX_SLOPES = 6'h2A;
  localparam logic [5:0] IDX_KNEE   = 6'h2B;

  // ----------------------------------------------------------------
  // Field layouts
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] gain_attack_rate;
    logic [3:0] gain_decay_rate;
    logic [1:0] fast_release_crest_threshold;
    logic [1:0] fast_release_decay_rate;
    logic [1:0] gain_floor;
    logic [1:0] gain_ceiling;
  } lc_timing_t;

  typedef struct packed {
    logic [9:0] unused;
    logic [2:0] upper_slope;
    logic [2:0] lower_slope;
  } lc_slopes_t;

  typedef struct packed {
    logic [4:0] unused;
    logic [5:0] knee_input_level;
    logic [4:0] knee_output_level;
  } lc_knee_t;

  // ----------------------------------------------------------------
  // Reset values and legal code limits
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_TIMING = 16'h3248;
  localparam logic [15:0] RST_SLOPES = 16'h0000;
  localparam logic [15:0] RST_KNEE   = 16'h0000;
  localparam logic [3:0]  ATK_MIN    = 4'h1;
  localparam logic [3:0]  ATK_MAX    = 4'hA;
  localparam logic [3:0]  DCY_MAX    = 4'h8;
  localparam logic [1:0]  QDCY_RSV   = 2'h3;
  localparam logic [2:0]  UP_MAX     = 3'h5;
  localparam logic [2:0]  LO_MAX     = 3'h4;
  localparam logic [5:0]  KIN_MAX    = 6'h3C;
  localparam logic [4:0]  KOUT_MAX   = 5'h1E;

endpackage

// File: dv/tb_top.sv
// Self-checking bench for the level compressor register block
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import lc_pkg::*;

  // ------------------------------------------------------------------
  // Setup
  // ------------------------------------------------------------------
  localparam logic [7:0] A_TIM = {IDX_TIMING, 2'h0};
  localparam logic [7:0] A_SLP = {IDX_SLOPES, 2'h0};
  localparam logic [7:0] A_KNE = {IDX_KNEE, 2'h0};
  // Unmapped word just past the knee register
  localparam logic [7:0] A_BAD = 8'hB0;
  // Whole run needs well under a thousand cycles
  localparam int         LIMIT = 3000;

  logic        aclk, aresetn;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  lc_timing_t  compressor_timing_gain_limits_q;
  lc_slopes_t  compressor_slopes_q;
  lc_knee_t    compressor_knee_point_q;
  int          bad_count = 0;
  int          tests_run = 0;
  int          cycles = 0;
  logic [15:0] tim_e;

  lc_level_compressor uut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .compressor_timing_gain_limits_q, .compressor_slopes_q, .compressor_knee_point_q
  );

  initial begin
    aclk = 1'h0;
    forever #10 aclk = ~aclk;
  end

  // ------------------------------------------------------------------
  // Bus and compare tasks
  // ------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", nm, exp, got);
      bad_count++;
    end
  endtask

  // Address and data offered together, each released once taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           input logic [3:0] s, input logic [1:0] er);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
      if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    // Idle edge so the next request never lands in this time step
    @(posedge aclk);
  endtask

  task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    chk("rdata", ed, s_axi_rdata);
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    @(posedge aclk);
  endtask

  // Port value is already settled when the write response arrives
  task automatic reg_chk(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] p;
    p = (a == A_TIM) ? {compressor_timing_gain_limits_q} :
        (a == A_SLP) ? {compressor_slopes_q} : {compressor_knee_point_q};
    chk("port", {16'h0, e}, {16'h0, p});
    axi_read(a, {16'h0, e}, RESP_OKAY);
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_reset();
    reg_chk(A_TIM, 16'h3248);
    reg_chk(A_SLP, 16'h0000);
    reg_chk(A_KNE, 16'h0000);
  endtask

  // Every code of every timing field; reserved ones keep the old value
  task automatic t_timing();
    logic [3:0] c;
    logic [1:0] b;
    tim_e = 16'h3248;
    for (int i = 0; i < 16; i++) begin
      c = i[3:0];
      b = c[1:0];
      if (c >= 4'h1 && c <= 4'hA) tim_e[15:12] = c;
      if (c <= 4'h8) tim_e[11:8] = c;
      tim_e[7:6] = b;
      if (b != 2'h3) tim_e[5:4] = b;
      tim_e[3:0] = {b, b};
      axi_write(A_TIM, {16'h0, c, c, b, b, b, b}, 4'h3, RESP_OKAY);
      reg_chk(A_TIM, tim_e);
    end
  endtask

  // Unused upper bits written as ones must read back zero
  task automatic t_slopes();
    logic [15:0] e;
    logic [2:0]  c;
    e = 16'h0000;
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      if (c <= 3'h5) e[5:3] = c;
      if (c <= 3'h4) e[2:0] = c;
      axi_write(A_SLP, {16'h0, 10'h3FF, c, c}, 4'h3, RESP_OKAY);
      reg_chk(A_SLP, e);
    end
  endtask

  task automatic t_knee();
    logic [5:0]  cs [7] = '{6'h00, 6'h01, 6'h1E, 6'h1F, 6'h3C, 6'h3D, 6'h3F};
    logic [15:0] e;
    e = 16'h0000;
    foreach (cs[i]) begin
      if (cs[i] <= 6'h3C) e[10:5] = cs[i];
      if (cs[i][4:0] <= 5'h1E) e[4:0] = cs[i][4:0];
      axi_write(A_KNE, {16'h0, 5'h1F, cs[i], cs[i][4:0]}, 4'h3, RESP_OKAY);
      reg_chk(A_KNE, e);
    end
  endtask

  // Byte strobes: the unselected byte holds its value
  task automatic t_strobe();
    tim_e[7:0] = 8'h22;
    axi_write(A_TIM, 32'hFFFF_5522, 4'h1, RESP_OKAY);
    reg_chk(A_TIM, tim_e);
    tim_e[15:8] = 8'h55;
    axi_write(A_TIM, 32'h0000_5500, 4'h2, RESP_OKAY);
    reg_chk(A_TIM, tim_e);
  endtask

  task automatic t_unmapped();
    axi_write(A_BAD, 32'h0000_FFFF, 4'hF, RESP_SLV);
    axi_read(A_BAD, 32'h0000_0000, RESP_SLV);
    reg_chk(A_TIM, tim_e);
  endtask

  // A reset in mid-run must bring every register back to its default
  task automatic t_midreset();
    axi_write(A_KNE, 32'h0000_0421, 4'h3, RESP_OKAY);
    reg_chk(A_KNE, 16'h0421);
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    tim_e = 16'h3248;
    reg_chk(A_TIM, tim_e);
    reg_chk(A_SLP, 16'h0000);
    reg_chk(A_KNE, 16'h0000);
  endtask

  // ------------------------------------------------------------------
  // Run control
  // ------------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      bad_count++;
      wrap_up();
    end
  end

  initial begin
    aresetn       = 1'h0;
    s_axi_awaddr  = 8'h00;
    s_axi_araddr  = 8'h00;
    s_axi_wdata   = 32'h0;
    s_axi_wstrb   = 4'h0;
    s_axi_awvalid = 1'h0;
    s_axi_wvalid  = 1'h0;
    s_axi_bready  = 1'h0;
    s_axi_arvalid = 1'h0;
    s_axi_rready  = 1'h0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    t_reset();
    t_timing();
    t_slopes();
    t_knee();
    t_strobe();
    t_unmapped();
    t_midreset();
    wrap_up();
  end

endmodule // tb_top

`default_nettype wire
